/* verilog/mcsp_pkg.sv */
// constants and types shared by both ends of the motor controller serial link
`default_nettype none
package mcsp_pkg;
  // ----------------------------------------------------------------
  // clock and bit rates
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 100_000_000;
  localparam int AUTO_MIN_BPS = 1200;
  localparam int AUTO_MAX_BPS = 500_000;
  localparam int FIX_MIN_BPS  = 1099;
  localparam int FIX_MAX_BPS  = 2_000_000;
  localparam int DIV_W        = 17;
  localparam int LOW_W        = 18;
  localparam logic [DIV_W-1:0] DIV_FIX_MIN = DIV_W'((CLK_HZ + FIX_MAX_BPS - 1) / FIX_MAX_BPS);
  localparam logic [DIV_W-1:0] DIV_FIX_MAX = DIV_W'(CLK_HZ / FIX_MIN_BPS);
  localparam logic [LOW_W-1:0] LOW_MIN     = LOW_W'(2 * (CLK_HZ / AUTO_MAX_BPS));
  localparam logic [LOW_W-1:0] LOW_MAX     = LOW_W'(2 * (CLK_HZ / AUTO_MIN_BPS));
  localparam int DATA_BITS    = 8;
  localparam int LOW_SHIFT    = 1;
  localparam int REST_SHIFT   = 2;
  // ----------------------------------------------------------------
  // times
  // ----------------------------------------------------------------
  localparam int QUIET_US     = 1000;
  localparam int DELAY_US     = 4000;
  localparam int TICK_US      = 10_000;
  localparam int QUIET_CYC    = CLK_HZ / 1_000_000 * QUIET_US;
  localparam int DELAY_CYC    = CLK_HZ / 1_000_000 * DELAY_US;
  localparam int TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int CNT_W        = 24;
  localparam int TMO_W        = 16;
  // ----------------------------------------------------------------
  // bytes and modes
  // ----------------------------------------------------------------
  localparam logic [7:0] IND_BYTE   = 8'hAA;
  localparam logic [7:0] BCAST_ADDR = 8'hFE;
  localparam int         DEVN_W     = 7;
  typedef enum logic [1:0] {
    CRC_OFF  = 2'b00,
    CRC_CMD  = 2'b01,
    CRC_BOTH = 2'b10
  } mcsp_crc_t;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } mcsp_tx_t;

  // clamp a bit period into a legal window
  function automatic logic [DIV_W-1:0] mcsp_clamp(input logic [DIV_W-1:0] d,
                                                  input logic [DIV_W-1:0] lo,
                                                  input logic [DIV_W-1:0] hi);
    mcsp_clamp = (d < lo) ? lo : ((d > hi) ? hi : d);
  endfunction
endpackage
`default_nettype wire

/* verilog/mcsp_link_if.sv */
// serial lines between host and motor controller
`timescale 1ns/1ns
`default_nettype none
interface mcsp_link_if;
  logic rx_line;
  logic tx_line;
  modport dev  (input rx_line, output tx_line);
  modport host (output rx_line, input tx_line);
endinterface
`default_nettype wire

/* verilog/mcsp_dev.sv */
// motor controller end: receivers, autobaud, transmitter, timeout
`timescale 1ns/1ns
`default_nettype none
module mcsp_rx (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  // control
  input  wire logic                       en,
  input  wire logic [mcsp_pkg::DIV_W-1:0] div,
  input  wire logic                       line,
  // received byte
  output logic      [7:0]                 data_r,
  output logic                            valid_r
);
  logic [mcsp_pkg::DIV_W-1:0] cnt_r;
  logic [3:0]                 bit_r;
  logic                       busy_r;
  logic [7:0]                 sh_r;

  // ----------------------------------------------------------------
  // mid-bit sampler
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    valid_r <= 1'b0;
    if (!nrst || !en) begin
      busy_r <= 1'b0;
      cnt_r  <= '0;
      bit_r  <= '0;
      sh_r   <= '0;
      data_r <= '0;
    end else if (!busy_r) begin
      if (!line) begin
        busy_r <= 1'b1;
        cnt_r  <= div >> 1;
        bit_r  <= '0;
      end
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end else begin
      cnt_r <= div - 1'b1;
      bit_r <= bit_r + 1'b1;
      if (bit_r == 4'h0 && line) begin
        busy_r <= 1'b0;
      end else if (bit_r >= 4'h1 && bit_r <= 4'(mcsp_pkg::DATA_BITS)) begin
        sh_r <= {line, sh_r[7:1]};
      end else if (bit_r == 4'(mcsp_pkg::DATA_BITS + 1)) begin
        busy_r  <= 1'b0;
        data_r  <= sh_r;
        valid_r <= line;
      end
    end
  end
endmodule

module mcsp_dev #(
  parameter int QUIET_CYC = mcsp_pkg::QUIET_CYC,
  parameter int DELAY_CYC = mcsp_pkg::DELAY_CYC,
  parameter int TICK_CYC  = mcsp_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  // link
  mcsp_link_if.dev                         link,
  input  wire logic                        transmit_passthrough_input,
  // settings
  input  wire logic                        cfg_ascii,
  input  wire logic                        cfg_auto_baud,
  input  wire mcsp_pkg::mcsp_crc_t         cfg_crc_mode,
  input  wire logic [mcsp_pkg::DEVN_W-1:0] cfg_dev_num,
  input  wire logic [mcsp_pkg::DIV_W-1:0]  cfg_fixed_div,
  input  wire logic                        cfg_resp_delay,
  input  wire logic [mcsp_pkg::TMO_W-1:0]  cfg_timeout,
  input  wire logic                        cfg_apply,
  // command byte stream to decoder
  output logic      [7:0]                  cmd_data_r,
  output logic                             cmd_valid_r,
  output logic                             cmd_addr_hit_r,
  input  wire logic                        cmd_ready,
  // decoder results
  input  wire logic                        pkt_done,
  input  wire logic                        pkt_crc_ok,
  // response bytes from decoder
  input  wire logic [7:0]                  resp_data,
  input  wire logic                        resp_valid,
  input  wire logic                        resp_last,
  input  wire logic [7:0]                  resp_crc,
  output logic                             resp_ready_r,
  // status
  output logic                             mode_ascii_r,
  output logic                             crc_active_r,
  output logic                             baud_locked_r,
  output logic      [mcsp_pkg::DIV_W-1:0]  baud_div_r,
  output logic                             overrun_r,
  output logic                             crc_err_r,
  output logic                             motor_stop_r
);
  logic                       auto_act;
  logic                       rx_en;
  logic [7:0]                 rxb;
  logic                       rxb_v;
  logic [7:0]                 ptb;
  logic                       ptb_v;
  logic [mcsp_pkg::CNT_W-1:0] quiet_r;
  logic [mcsp_pkg::LOW_W-1:0] low_r;
  logic [mcsp_pkg::LOW_W+1:0] rest_r;
  logic                       meas_r;
  logic                       skip_r;
  logic                       ind_v_r;
  logic [7:0]                 pt_hold_r;
  logic                       pt_pend_r;
  logic                       crc_pend_r;
  logic                       in_resp_r;
  logic                       delay_ok_r;
  logic [mcsp_pkg::CNT_W-1:0] dly_r;
  mcsp_pkg::mcsp_tx_t         tx_st_r;
  logic [mcsp_pkg::DIV_W-1:0] tx_cnt_r;
  logic [2:0]                 tx_bit_r;
  logic [7:0]                 tx_sh_r;
  logic                       tx_line_r;
  logic [mcsp_pkg::CNT_W-1:0] tick_r;
  logic [mcsp_pkg::TMO_W-1:0] tmo_r;
  logic                       tx_take;
  logic                       take_resp;
  logic                       take_crc;

  assign auto_act     = cfg_auto_baud && !cfg_ascii;
  assign rx_en        = (quiet_r == '0) && baud_locked_r && !skip_r;
  assign link.tx_line = tx_line_r;

  // ----------------------------------------------------------------
  // mode status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mode_ascii_r <= 1'b0;
      crc_active_r <= 1'b0;
    end else begin
      mode_ascii_r <= cfg_ascii;
      crc_active_r <= !cfg_ascii && (cfg_crc_mode != mcsp_pkg::CRC_OFF);
    end
  end

  // ----------------------------------------------------------------
  // power-up quiet time
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      quiet_r <= mcsp_pkg::CNT_W'(QUIET_CYC);
    end else if (quiet_r != '0) begin
      quiet_r <= quiet_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // bit rate: fixed or measured from indication byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    ind_v_r <= 1'b0;
    if (!nrst || cfg_apply) begin
      baud_locked_r <= 1'b0;
      baud_div_r    <= mcsp_pkg::DIV_FIX_MIN;
      meas_r        <= 1'b0;
      skip_r        <= 1'b0;
      low_r         <= '0;
      rest_r        <= '0;
    end else if (!auto_act) begin
      baud_locked_r <= 1'b1;
      baud_div_r    <= mcsp_pkg::mcsp_clamp(cfg_fixed_div, mcsp_pkg::DIV_FIX_MIN,
                                            mcsp_pkg::DIV_FIX_MAX);
    end else if (!baud_locked_r && quiet_r == '0) begin
      if (!link.rx_line) begin
        meas_r <= 1'b1;
        low_r  <= (low_r == '1) ? low_r : low_r + 1'b1;
      end else if (meas_r) begin
        meas_r <= 1'b0;
        low_r  <= '0;
        if (low_r >= mcsp_pkg::LOW_MIN - 1'b1 && low_r <= mcsp_pkg::LOW_MAX + 1'b1) begin
          baud_locked_r <= 1'b1;
          skip_r        <= 1'b1;
          baud_div_r    <= mcsp_pkg::DIV_W'(low_r >> mcsp_pkg::LOW_SHIFT);
          rest_r        <= {1'b0, low_r, 1'b0} << (mcsp_pkg::REST_SHIFT - 1);
        end
      end
    end else if (skip_r) begin
      rest_r <= rest_r - 1'b1;
      if (rest_r == '0) begin
        skip_r  <= 1'b0;
        ind_v_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // receivers
  // ----------------------------------------------------------------
  mcsp_rx u_rx (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .en      (rx_en),
    .div     (baud_div_r),
    .line    (link.rx_line),
    .data_r  (rxb),
    .valid_r (rxb_v)
  );

  mcsp_rx u_pt (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .en      (baud_locked_r),
    .div     (baud_div_r),
    .line    (transmit_passthrough_input),
    .data_r  (ptb),
    .valid_r (ptb_v)
  );

  // ----------------------------------------------------------------
  // command byte holding register and overrun
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    overrun_r <= 1'b0;
    if (!nrst) begin
      cmd_valid_r    <= 1'b0;
      cmd_data_r     <= '0;
      cmd_addr_hit_r <= 1'b0;
    end else if ((rxb_v || ind_v_r) && cmd_valid_r && !cmd_ready) begin
      overrun_r <= 1'b1;
    end else if (rxb_v || ind_v_r) begin
      cmd_valid_r    <= 1'b1;
      cmd_data_r     <= ind_v_r ? mcsp_pkg::IND_BYTE : rxb;
      cmd_addr_hit_r <= ind_v_r ? 1'b0 : (rxb == {1'b0, cfg_dev_num}) ||
                        (rxb == mcsp_pkg::BCAST_ADDR);
    end else if (cmd_ready) begin
      cmd_valid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // crc error and command timeout
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    crc_err_r <= 1'b0;
    if (nrst && pkt_done && crc_active_r && !pkt_crc_ok) begin
      crc_err_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst || (pkt_done && (pkt_crc_ok || !crc_active_r))) begin
      tick_r       <= '0;
      tmo_r        <= '0;
      motor_stop_r <= 1'b0;
    end else begin
      tick_r <= (tick_r == mcsp_pkg::CNT_W'(TICK_CYC - 1)) ? '0 : tick_r + 1'b1;
      if (tick_r == mcsp_pkg::CNT_W'(TICK_CYC - 1) && tmo_r != '1) begin
        tmo_r <= tmo_r + 1'b1;
      end
      if (cfg_timeout != '0 && tmo_r >= cfg_timeout) begin
        motor_stop_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit source selection and response delay
  // ----------------------------------------------------------------
  assign tx_take   = (tx_st_r == mcsp_pkg::TX_IDLE) && baud_locked_r;
  assign take_crc  = tx_take && crc_pend_r;
  assign take_resp = tx_take && !crc_pend_r && resp_valid && (delay_ok_r || in_resp_r);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dly_r      <= '0;
      delay_ok_r <= 1'b0;
    end else if (!resp_valid || in_resp_r) begin
      dly_r      <= '0;
      delay_ok_r <= 1'b0;
    end else if (!cfg_resp_delay) begin
      delay_ok_r <= 1'b1;
    end else if (dly_r == mcsp_pkg::CNT_W'(DELAY_CYC - 1)) begin
      delay_ok_r <= 1'b1;
    end else begin
      dly_r <= dly_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    resp_ready_r <= 1'b0;
    if (!nrst) begin
      in_resp_r  <= 1'b0;
      crc_pend_r <= 1'b0;
      pt_pend_r  <= 1'b0;
      pt_hold_r  <= '0;
    end else begin
      if (ptb_v) begin
        pt_pend_r <= 1'b1;
        pt_hold_r <= ptb;
      end else if (tx_take && !take_crc && !take_resp && !in_resp_r) begin
        pt_pend_r <= 1'b0;
      end
      if (take_resp) begin
        resp_ready_r <= 1'b1;
        in_resp_r    <= !resp_last;
        crc_pend_r   <= resp_last && !cfg_ascii &&
                        (cfg_crc_mode == mcsp_pkg::CRC_BOTH);
      end else if (take_crc) begin
        crc_pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tx_st_r   <= mcsp_pkg::TX_IDLE;
      tx_cnt_r  <= '0;
      tx_bit_r  <= '0;
      tx_sh_r   <= '0;
      tx_line_r <= 1'b1;
    end else begin
      case (tx_st_r)
        mcsp_pkg::TX_IDLE: begin
          tx_line_r <= 1'b1;
          if (take_crc || take_resp || (tx_take && pt_pend_r && !in_resp_r)) begin
            tx_sh_r   <= take_crc ? resp_crc : (take_resp ? resp_data : pt_hold_r);
            tx_st_r   <= mcsp_pkg::TX_START;
            tx_cnt_r  <= baud_div_r - 1'b1;
            tx_line_r <= 1'b0;
          end
        end
        mcsp_pkg::TX_START, mcsp_pkg::TX_DATA: begin
          if (tx_cnt_r != '0) begin
            tx_cnt_r <= tx_cnt_r - 1'b1;
          end else begin
            tx_cnt_r  <= baud_div_r - 1'b1;
            tx_line_r <= tx_sh_r[0];
            tx_sh_r   <= tx_sh_r >> 1;
            tx_bit_r  <= (tx_st_r == mcsp_pkg::TX_START) ? 3'h0 : tx_bit_r + 1'b1;
            if (tx_st_r == mcsp_pkg::TX_DATA && tx_bit_r == 3'h7) begin
              tx_st_r   <= mcsp_pkg::TX_STOP;
              tx_line_r <= 1'b1;
            end else begin
              tx_st_r <= mcsp_pkg::TX_DATA;
            end
          end
        end
        mcsp_pkg::TX_STOP: begin
          if (tx_cnt_r != '0) begin
            tx_cnt_r <= tx_cnt_r - 1'b1;
          end else begin
            tx_st_r <= mcsp_pkg::TX_IDLE;
          end
        end
        default: tx_st_r <= mcsp_pkg::TX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* verilog/mcsp_host.sv */
// host end: quiet wait, indication byte, command transmit, response receive
`timescale 1ns/1ns
`default_nettype none
module mcsp_host #(
  parameter int QUIET_CYC = mcsp_pkg::QUIET_CYC
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  // link
  mcsp_link_if.host                       link,
  // settings
  input  wire logic [mcsp_pkg::DIV_W-1:0] bit_div,
  input  wire logic                       auto_baud,
  input  wire logic                       crc_en,
  // command bytes
  input  wire logic [7:0]                 send_data,
  input  wire logic                       send_valid,
  input  wire logic                       send_last,
  input  wire logic [7:0]                 send_crc,
  output logic                            send_ready_r,
  // response bytes
  output logic      [7:0]                 recv_data_r,
  output logic                            recv_valid_r
);
  logic [mcsp_pkg::CNT_W-1:0] quiet_r;
  logic                       ind_done_r;
  logic                       crc_pend_r;
  mcsp_pkg::mcsp_tx_t         st_r;
  logic [mcsp_pkg::DIV_W-1:0] cnt_r;
  logic [3:0]                 bit_r;
  logic [8:0]                 sh_r;
  logic                       line_r;
  logic                       idle;

  assign idle         = (st_r == mcsp_pkg::TX_IDLE) && (quiet_r == '0);
  assign link.rx_line = line_r;

  // ----------------------------------------------------------------
  // response receiver
  // ----------------------------------------------------------------
  mcsp_rx u_rx (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .en      (1'b1),
    .div     (bit_div),
    .line    (link.tx_line),
    .data_r  (recv_data_r),
    .valid_r (recv_valid_r)
  );

  // ----------------------------------------------------------------
  // quiet time after reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      quiet_r <= mcsp_pkg::CNT_W'(QUIET_CYC);
    end else if (quiet_r != '0) begin
      quiet_r <= quiet_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // transmitter: indication byte, command bytes, check byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    send_ready_r <= 1'b0;
    if (!nrst) begin
      st_r       <= mcsp_pkg::TX_IDLE;
      ind_done_r <= 1'b0;
      crc_pend_r <= 1'b0;
      cnt_r      <= '0;
      bit_r      <= '0;
      sh_r       <= '1;
      line_r     <= 1'b1;
    end else begin
      case (st_r)
        mcsp_pkg::TX_IDLE: begin
          line_r <= 1'b1;
          if (idle && auto_baud && !ind_done_r) begin
            ind_done_r <= 1'b1;
            sh_r       <= {1'b1, mcsp_pkg::IND_BYTE};
            st_r       <= mcsp_pkg::TX_START;
          end else if (idle && crc_pend_r) begin
            crc_pend_r <= 1'b0;
            sh_r       <= {1'b1, send_crc};
            st_r       <= mcsp_pkg::TX_START;
          end else if (idle && send_valid) begin
            send_ready_r <= 1'b1;
            crc_pend_r   <= send_last && crc_en;
            sh_r         <= {1'b1, send_data};
            st_r         <= mcsp_pkg::TX_START;
          end
          if (idle && (send_valid || crc_pend_r || (auto_baud && !ind_done_r))) begin
            line_r <= 1'b0;
            cnt_r  <= bit_div - 1'b1;
            bit_r  <= '0;
          end
        end
        mcsp_pkg::TX_START: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            cnt_r  <= bit_div - 1'b1;
            line_r <= sh_r[0];
            sh_r   <= {1'b1, sh_r[8:1]};
            bit_r  <= bit_r + 1'b1;
            if (bit_r == 4'(mcsp_pkg::DATA_BITS)) begin
              st_r <= mcsp_pkg::TX_STOP;
            end
          end
        end
        mcsp_pkg::TX_STOP: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            st_r <= mcsp_pkg::TX_IDLE;
          end
        end
        default: st_r <= mcsp_pkg::TX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* dv/mcsp_link_assertions.sv */
// wire-level checks on the host and device serial lines
`timescale 1ns/1ns
`default_nettype none
module mcsp_link_assertions #(
  parameter int DIV   = 50,
  parameter int QUIET = 20
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic rx_line,
  input wire logic tx_line
);
  // ----------------------------------------------------------------
  // run lengths of each line level
  // ----------------------------------------------------------------
  logic [19:0] rx_run_r;
  logic [19:0] tx_run_r;
  logic        rx_q_r;
  logic        tx_q_r;
  logic        seen_r;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_run_r <= 20'h00000;
      tx_run_r <= 20'h00000;
      rx_q_r   <= 1'b1;
      tx_q_r   <= 1'b1;
      seen_r   <= 1'b0;
    end else begin
      rx_run_r <= (rx_line != rx_q_r) ? 20'h00001 : rx_run_r + 20'h00001;
      tx_run_r <= (tx_line != tx_q_r) ? 20'h00001 : tx_run_r + 20'h00001;
      rx_q_r   <= rx_line;
      tx_q_r   <= tx_line;
      seen_r   <= seen_r | !rx_line;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_tx_reset;
    @(posedge clk_sys) disable iff (1'b0) !nrst |=> tx_line;
  endproperty
  property p_rx_quiet;
    rx_q_r && !rx_line && !seen_r |-> rx_run_r >= QUIET;
  endproperty
  property p_rx_low_unit;
    rx_line && !rx_q_r |-> (rx_run_r % DIV) == 0;
  endproperty
  property p_rx_low_max;
    !rx_line && !rx_q_r |-> rx_run_r < 9 * DIV;
  endproperty
  property p_rx_stop;
    rx_q_r && !rx_line && seen_r |-> rx_run_r >= DIV;
  endproperty
  property p_tx_low_unit;
    $rose(tx_line) && !tx_q_r |-> (tx_run_r % DIV) == 0;
  endproperty
  property p_tx_low_max;
    !tx_line && !tx_q_r |-> tx_run_r < 9 * DIV;
  endproperty
  property p_tx_stop;
    tx_q_r && !tx_line |-> tx_run_r >= DIV;
  endproperty
  a_tx_reset:    assert property (p_tx_reset)    else $error("tx not idle in reset");
  a_rx_quiet:    assert property (p_rx_quiet)    else $error("rx early after reset");
  a_rx_low_unit: assert property (p_rx_low_unit) else $error("rx low run not whole bits");
  a_rx_low_max:  assert property (p_rx_low_max)  else $error("rx low too long");
  a_rx_stop:     assert property (p_rx_stop)     else $error("rx stop too short");
  a_tx_low_unit: assert property (p_tx_low_unit) else $error("tx low run not whole bits");
  a_tx_low_max:  assert property (p_tx_low_max)  else $error("tx low too long");
  a_tx_stop:     assert property (p_tx_stop)     else $error("tx stop too short");
  c_rx_frame: cover property (rx_q_r && !rx_line);
  c_tx_frame: cover property (tx_q_r && !tx_line);
  c_both:     cover property (seen_r && tx_q_r && !tx_line);
endmodule
`default_nettype wire

/* dv/tb_mcsp_dev.sv */
// self-checking bench joining host and device serial ends
`timescale 1ns/1ns
`default_nettype none
module tb_mcsp_dev;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                clk_sys    = 1'b0;
  logic                nrst       = 1'b0;
  mcsp_pkg::mcsp_crc_t crc_mode   = mcsp_pkg::CRC_OFF;
  logic [15:0]         cfg_timeout = 16'h0000;
  logic [7:0]          send_data  = 8'h00;
  logic                send_valid = 1'b0;
  logic                cmd_ready  = 1'b0;
  logic                pkt_done   = 1'b0;
  logic                pkt_crc_ok = 1'b0;
  logic [7:0]          resp_data  = 8'h00;
  logic                resp_valid = 1'b0;
  logic [7:0]          resp_crc   = 8'h00;
  logic [7:0]          cmd_data_r, recv_data_r, rq[$];
  logic [16:0]         baud_div_r;
  logic                cmd_valid_r, cmd_addr_hit_r, resp_ready_r, overrun_r, crc_err_r;
  logic                motor_stop_r, send_ready_r, recv_valid_r;
  logic                mode_ascii_r, crc_active_r, baud_locked_r;
  logic [16:0]         div        = 17'h00032;
  logic [7:0]          send_crc   = 8'h00;
  logic                pt_line = 1'b1, resp_last = 1'b1, crc_en = 1'b0, send_last = 1'b0;
  logic                ascii = 1'b0, auto_baud = 1'b0, resp_dly = 1'b0, apply = 1'b0;
  int                  checks = 0, mismatches = 0, n_ovr = 0, n_crc = 0, n;
  mcsp_link_if link();
  mcsp_dev #(.QUIET_CYC(20), .DELAY_CYC(50), .TICK_CYC(100)) mcsp_dev_inst (
    .clk_sys, .nrst, .link(link.dev), .transmit_passthrough_input(pt_line), .cfg_ascii(ascii),
    .cfg_auto_baud(auto_baud), .cfg_crc_mode(crc_mode), .cfg_dev_num(7'h0D),
    .cfg_fixed_div(div), .cfg_resp_delay(resp_dly), .cfg_timeout, .cfg_apply(apply),
    .cmd_data_r, .cmd_valid_r, .cmd_addr_hit_r, .cmd_ready, .pkt_done, .pkt_crc_ok,
    .resp_data, .resp_valid, .resp_last, .resp_crc, .resp_ready_r, .mode_ascii_r,
    .crc_active_r, .baud_locked_r, .baud_div_r, .overrun_r, .crc_err_r, .motor_stop_r);
  mcsp_host #(.QUIET_CYC(20)) mcsp_host_inst (
    .clk_sys, .nrst, .link(link.host), .bit_div(div), .auto_baud, .crc_en,
    .send_data, .send_valid, .send_last, .send_crc, .send_ready_r,
    .recv_data_r, .recv_valid_r);
  mcsp_link_assertions mcsp_link_assertions_inst (
    .clk_sys(clk_sys), .nrst(nrst), .rx_line(link.rx_line), .tx_line(link.tx_line));
  // ----------------------------------------------------------------
  // clock, monitors, helpers
  // ----------------------------------------------------------------
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (overrun_r === 1'b1) n_ovr++;
    if (crc_err_r === 1'b1) n_crc++;
    if (recv_valid_r === 1'b1) rq.push_back(recv_data_r);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cy(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic send(input logic [7:0] d);
    send_data = d;
    send_valid = 1'b1;
    for (n = 0; n < 3000 && send_ready_r !== 1'b1; n++) @(posedge clk_sys);
    #1;
    send_valid = 1'b0;
  endtask
  task automatic get_cmd(input logic [7:0] d, input logic hit);
    for (int i = 0; i < 3000 && cmd_valid_r !== 1'b1; i++) cy(1);
    chk(cmd_data_r, d);
    chk(cmd_addr_hit_r, hit);
    cmd_ready = 1'b1;
    cy(1);
    cmd_ready = 1'b0;
  endtask
  task automatic t_resp(input mcsp_pkg::mcsp_crc_t m, input int cnt);
    crc_mode = m;
    rq.delete();
    {resp_data, resp_crc, resp_valid} = {8'h3C, 8'hA5, 1'b1};
    for (int i = 0; i < 500 && resp_ready_r !== 1'b1; i++) @(posedge clk_sys);
    #1;
    resp_valid = 1'b0;
    cy(1400);
    chk(rq.size(), cnt);
    chk(rq[0], 8'h3C);
    if (cnt == 2) chk(rq[1], 8'hA5);
  endtask
  task automatic t_pkt(input mcsp_pkg::mcsp_crc_t m, input logic ok, input int e);
    crc_mode = m;
    cy(2);
    n = n_crc;
    {pkt_done, pkt_crc_ok} = {1'b1, ok};
    cy(1);
    pkt_done = 1'b0;
    cy(4);
    chk(n_crc - n, e);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #300000;
    mismatches++;
    stop_test();
  end
  initial begin
    cy(8);
    nrst = 1'b1;
    cy(2);
    chk(baud_div_r, 17'h00032);
    fork
      begin
        send(8'h0D);
        send(8'h55);
      end
      begin
        get_cmd(8'h0D, 1'b1);
        get_cmd(8'h55, 1'b0);
      end
    join
    {crc_en, send_last, send_crc} = {1'b1, 1'b1, 8'h5A};
    fork
      send(8'h11);
      begin
        get_cmd(8'h11, 1'b0);
        get_cmd(8'h5A, 1'b0);
      end
    join
    {crc_en, send_last} = 2'b00;
    $display("back to back commands done");
    send(8'h11);
    send(8'h22);
    cy(700);
    chk(n_ovr, 1);
    get_cmd(8'h11, 1'b0);
    $display("overrun done");
    t_resp(mcsp_pkg::CRC_BOTH, 2);
    t_resp(mcsp_pkg::CRC_CMD, 1);
    $display("responses done");
    {ascii, auto_baud} = 2'b11;
    crc_mode = mcsp_pkg::CRC_BOTH;
    apply = 1'b1;
    cy(1);
    apply = 1'b0;
    chk(mode_ascii_r, 1'b1);
    get_cmd(8'hAA, 1'b0);
    chk(crc_active_r, 1'b0);
    chk(baud_locked_r, 1'b1);
    {ascii, auto_baud} = 2'b00;
    $display("ascii mode done");
    t_pkt(mcsp_pkg::CRC_OFF, 1'b0, 0);
    t_pkt(mcsp_pkg::CRC_CMD, 1'b0, 1);
    t_pkt(mcsp_pkg::CRC_CMD, 1'b1, 0);
    $display("crc errors done");
    cfg_timeout = 16'h0002;
    t_pkt(mcsp_pkg::CRC_OFF, 1'b1, 0);
    cy(100);
    chk(motor_stop_r, 1'b0);
    cy(250);
    chk(motor_stop_r, 1'b1);
    t_pkt(mcsp_pkg::CRC_OFF, 1'b1, 0);
    chk(motor_stop_r, 1'b0);
    $display("timeout done");
    stop_test();
  end
endmodule
`default_nettype wire
